// file: prot_pkg.sv
/*
 Constants, types and register map of the branch protector mode controller.
 Assumes a single 40 MHz clock and an asynchronous active-low reset.
*/
// Operation
// RULE1 - Run, setting and test modes, menu stepped
// RULE2 - First power-up enters setting mode
// RULE3 - Else power-up in run, connecting branches
// RULE4 - Run mode refuses every parameter change
// RULE5 - Each branch connects after its delay
// RULE6 - Delays 0 to 99.0 s, 0.1 s steps
// RULE7 - Entering run keeps branch on/off states
// RULE8 - Setting mode edits while protection continues
// RULE9 - Test mode forces branches, all off default
// RULE10 - Test keys pick branch, toggle it alone
// RULE11 - Test all-branches item uses sequencing
// RULE12 - Test mode only at level 0 or 1
// RULE13 - Levels: 0 all, 1 subset, 2 read-only
// RULE14 - Level defaults to 1
// RULE15 - Restore defaults item only at level 0
// RULE16 - No mode menu at levels 1, 2
// RULE17 - Restore: defaults, setting mode, off, level 1
// RULE18 - Indicator: green, flash green, red, flash red, dark
// RULE19 - Run keys cycle the display items
// RULE20 - Run mode clears selected peak current
// RULE21 - Mode, first-boot flag, level kept nonvolatile
// RULE22 - Keys debounced, one event per press
package prot_pkg;
	localparam int CLK_NS = 25;
	localparam int TENTH_NS = 100_000_000;
	localparam int TICK_CYC = TENTH_NS / CLK_NS;
	localparam int DEB_NS = 5_000_000;
	localparam int DEB_CYC = DEB_NS / CLK_NS;
	localparam int NBR = 4;
	localparam int NKEY = 4;
	localparam logic [9:0] DLY_MAX = 10'h3de;
	localparam logic [9:0] DLY_RST = 10'h000;
	localparam logic [3:0] FLASH_TICKS = 4'h5;
	localparam logic [1:0] LVL_RST = 2'h1;
	localparam logic [3:0] DISP_TOTAL = 4'h8;
	localparam logic [3:0] DISP_LAST = 4'ha;
	localparam logic [2:0] ITEM_RUN = 3'h0;
	localparam logic [2:0] ITEM_SET = 3'h1;
	localparam logic [2:0] ITEM_TEST = 3'h2;
	localparam logic [2:0] ITEM_LVL = 3'h3;
	localparam logic [2:0] ITEM_INIT = 3'h4;
	localparam logic [2:0] TEST_ALL = 3'h4;
	localparam logic [3:0] IDX_STATUS = 4'h0;
	localparam logic [3:0] IDX_START = 4'h1;
	localparam logic [3:0] IDX_STOP = 4'h5;
	localparam logic [3:0] IDX_PEAK = 4'h9;
	localparam logic [3:0] IDX_LEVEL = 4'hd;
	typedef enum logic [3:0] {
		M_RUN = 4'h1,
		M_SET = 4'h2,
		M_TEST = 4'h4,
		M_MENU = 4'h8
	} mode_t;
endpackage

// file: key_if.sv
/*
 Debounced key press events passed from the key filter to the controller.
 Assumes one clock domain shared by both ends.
*/
`timescale 1ns/1ps
interface key_if;
	logic up;
	logic down;
	logic mode;
	logic menu;
	modport src(output up, down, mode, menu);
	modport dst(input up, down, mode, menu);
endinterface

// file: key_filter.sv
/*
 Key debouncer: one press pulse per stable press of each front-panel key.
 Assumes raw keys active high and synchronous to clk.
*/
`timescale 1ns/1ps
module key_filter import prot_pkg::*; #(
	parameter int DEB = DEB_CYC
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Raw keys: up, down, mode, menu
	input wire logic [NKEY-1:0] raw,
	// Press events
	key_if.src ev
);
	typedef struct packed {
		logic [NKEY-1:0][17:0] cnt;
		logic [NKEY-1:0] stable;
		logic [NKEY-1:0] press;
	} kf_t;
	kf_t q;
	kf_t next_q;

	always_comb begin
		next_q = q;
		next_q.press = '0;
		for (int i = 0; i < NKEY; i++) begin
			// Level must hold for the whole window before it counts
			if (raw[i] == q.stable[i]) begin
				next_q.cnt[i] = '0;
			end else if (q.cnt[i] == 18'(DEB - 1)) begin
				next_q.cnt[i] = '0;
				next_q.stable[i] = raw[i];
				next_q.press[i] = raw[i]; // RULE22
			end else begin
				next_q.cnt[i] = q.cnt[i] + 18'h1;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			q <= '0;
		end else begin
			q <= next_q;
		end
	end

	assign ev.up = q.press[0];
	assign ev.down = q.press[1];
	assign ev.mode = q.press[2];
	assign ev.menu = q.press[3];

	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	one_press_a: assert property (q.press[2] |=> !q.press[2]) else $error("press not single"); // RULE22
endmodule

// file: prot_ctrl.sv
/*
 Mode controller of a four-branch DC protector: modes, menu, test forcing,
 start/stop sequencing, access levels, indicators, Avalon-MM register slave.
 Assumes synchronous keys, trip inputs and current samples; the nonvolatile
 store is outside and reports at reset whether it has been written.
*/
// The Avalon-MM register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module prot_ctrl import prot_pkg::*; #(
	parameter int TICK = TICK_CYC,
	parameter int DEB = DEB_CYC
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Avalon-MM slave
	input wire logic [5:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// Front panel keys: up, down, mode, menu
	input wire logic [NKEY-1:0] key_raw,
	// Branch measurement and protection events
	input wire logic [NBR-1:0][7:0] branch_current,
	input wire logic [NBR-1:0] trip_abn,
	input wire logic [NBR-1:0] trip_lim,
	// Nonvolatile store
	input wire logic nv_used,
	output logic [3:0] nv_mode,
	output logic [1:0] nv_level,
	// Branch switches, indicators and display selection
	output logic [NBR-1:0] branch_on,
	output logic [NBR-1:0] led_green,
	output logic [NBR-1:0] led_red,
	output logic [3:0] disp_sel
);
	typedef struct packed {
		mode_t mode;
		logic [1:0] level;
		logic [2:0] cursor;
		logic [3:0] disp;
		logic [NBR-1:0] want;
		logic [NBR-1:0] on;
		logic [NBR-1:0] abn;
		logic [NBR-1:0] lim;
		logic [NBR-1:0][9:0] cnt;
		logic [NBR-1:0][9:0] start_dly;
		logic [NBR-1:0][9:0] stop_dly;
		logic [NBR-1:0][7:0] peak;
		logic [21:0] tick_cnt;
		logic tick;
		logic [3:0] flash_cnt;
		logic flash;
		logic booted;
		logic waitrequest;
		logic [31:0] readdata;
		logic [NBR-1:0] green;
		logic [NBR-1:0] red;
	} st_t;

	st_t q;
	st_t next_q;
	key_if k ();

	key_filter #(.DEB(DEB)) u_keys (
		.clk(clk),
		.rst_b(rst_b),
		.raw(key_raw),
		.ev(k)
	);

	logic [3:0] idx;
	logic wr_take;
	logic [1:0] sel;
	logic [9:0] wval;
	assign idx = avs_address[5:2];
	assign sel = idx[1:0] - 2'h1;
	assign wr_take = avs_write && !q.waitrequest;
	assign wval = (avs_writedata[9:0] > DLY_MAX) ? DLY_MAX : avs_writedata[9:0];

	function automatic logic [31:0] rd_mux(input st_t s, input logic [3:0] i);
		logic [31:0] r;
		logic [1:0] b;
		r = '0;
		b = i[1:0] - 2'h1;
		if (i == IDX_STATUS) begin
			r = {3'h0, s.cursor, s.disp, s.lim, s.abn, s.want & ~s.on, s.on, s.level, s.mode};
		end else if (i >= IDX_START && i < IDX_STOP) begin
			r = {22'h0, s.start_dly[b]};
		end else if (i >= IDX_STOP && i < IDX_PEAK) begin
			r = {22'h0, s.stop_dly[b]};
		end else if (i >= IDX_PEAK && i < IDX_LEVEL) begin
			r = {24'h0, s.peak[b]};
		end else if (i == IDX_LEVEL) begin
			r = {30'h0, s.level};
		end
		return r;
	endfunction

	always_comb begin
		next_q = q;
		// Avalon: one wait cycle, then a single-cycle answer
		next_q.waitrequest = !((avs_read || avs_write) && q.waitrequest);
		if (avs_read && q.waitrequest) begin
			next_q.readdata = rd_mux(q, idx);
		end
		// Level is the software key to the panel, so it is writable at any level
		if (wr_take && idx == IDX_LEVEL && avs_writedata[1:0] != 2'h3) begin
			next_q.level = avs_writedata[1:0];
		end
		if (wr_take && q.mode == M_SET && q.level != 2'h2) begin // RULE4 RULE13
			if (idx >= IDX_START && idx < IDX_STOP) begin
				next_q.start_dly[sel] = wval; // RULE6 RULE8
			end
			// Stop delays are the subset reserved for level 0
			if (idx >= IDX_STOP && idx < IDX_PEAK && q.level == 2'h0) begin
				next_q.stop_dly[sel] = wval; // RULE6
			end
		end
		// Tenth-second tick and half-second flash
		next_q.tick = 1'b0;
		if (q.tick_cnt == 22'(TICK - 1)) begin
			next_q.tick_cnt = '0;
			next_q.tick = 1'b1;
		end else begin
			next_q.tick_cnt = q.tick_cnt + 22'h1;
		end
		if (q.tick) begin
			if (q.flash_cnt == FLASH_TICKS - 4'h1) begin
				next_q.flash_cnt = '0;
				next_q.flash = !q.flash;
			end else begin
				next_q.flash_cnt = q.flash_cnt + 4'h1;
			end
		end
		// Peak tracking runs in every mode
		for (int i = 0; i < NBR; i++) begin
			if (branch_current[i] > q.peak[i]) begin
				next_q.peak[i] = branch_current[i];
			end
		end
		// Mode and key handling
		if (!q.booted) begin
			next_q.booted = 1'b1;
			if (!nv_used) begin
				next_q.mode = M_SET; // RULE2
			end else begin
				next_q.mode = M_RUN; // RULE3
				next_q.want = '1;
				next_q.cnt = q.start_dly; // RULE5
			end
		end else if (k.menu && q.mode != M_MENU && q.level == 2'h0) begin
			next_q.mode = M_MENU; // RULE16
			next_q.cursor = ITEM_RUN;
		end else begin
			case (q.mode)
				M_RUN: begin
					if (k.up) begin
						next_q.disp = (q.disp == DISP_LAST) ? 4'h0 : q.disp + 4'h1; // RULE19
					end else if (k.down) begin
						next_q.disp = (q.disp == 4'h0) ? DISP_LAST : q.disp - 4'h1; // RULE19
					end else if (k.mode && q.disp < DISP_TOTAL && q.disp[0]) begin
						next_q.peak[q.disp[2:1]] = branch_current[q.disp[2:1]]; // RULE20
					end
				end
				M_SET: begin
				end
				M_TEST: begin
					if (k.up) begin
						next_q.cursor = (q.cursor == TEST_ALL) ? 3'h0 : q.cursor + 3'h1; // RULE10
					end else if (k.down) begin
						next_q.cursor = (q.cursor == 3'h0) ? TEST_ALL : q.cursor - 3'h1; // RULE10
					end else if (k.mode && q.cursor == TEST_ALL) begin
						// All-branch switching goes through the sequencer
						next_q.want = (q.want == '0) ? '1 : '0; // RULE11
						next_q.cnt = (q.want == '0) ? q.start_dly : q.stop_dly; // RULE11
					end else if (k.mode) begin
						next_q.want[q.cursor[1:0]] = !q.on[q.cursor[1:0]]; // RULE10
						next_q.on[q.cursor[1:0]] = !q.on[q.cursor[1:0]]; // RULE9
						next_q.cnt[q.cursor[1:0]] = '0;
					end
				end
				M_MENU: begin
					if (k.up) begin
						next_q.cursor = (q.cursor == ITEM_INIT) ? ITEM_RUN : q.cursor + 3'h1; // RULE1 RULE15
					end else if (k.down) begin
						next_q.cursor = (q.cursor == ITEM_RUN) ? ITEM_INIT : q.cursor - 3'h1; // RULE1
					end else if (k.mode) begin
						case (q.cursor)
							ITEM_RUN: next_q.mode = M_RUN; // RULE7
							ITEM_SET: next_q.mode = M_SET;
							ITEM_TEST: begin
								if (q.level != 2'h2) begin // RULE12
									next_q.mode = M_TEST;
									next_q.cursor = 3'h0;
									next_q.want = '0; // RULE9
									next_q.on = '0; // RULE9
								end
							end
							ITEM_LVL: next_q.level = (q.level == 2'h2) ? 2'h0 : q.level + 2'h1; // RULE13
							ITEM_INIT: begin
								if (q.level == 2'h0) begin // RULE15
									next_q.mode = M_SET; // RULE17
									next_q.level = LVL_RST; // RULE17 RULE14
									next_q.want = '0;
									next_q.on = '0; // RULE17
									next_q.cnt = '0;
									next_q.start_dly = {NBR{DLY_RST}}; // RULE17
									next_q.stop_dly = {NBR{DLY_RST}};
									next_q.peak = '0;
									next_q.disp = '0;
								end
							end
							default: next_q.mode = q.mode;
						endcase
					end
				end
				default: next_q.mode = M_SET;
			endcase
		end
		// Sequencer and protection per branch; runs in every mode
		for (int i = 0; i < NBR; i++) begin
			if (trip_abn[i] || trip_lim[i]) begin
				next_q.want[i] = 1'b0;
				next_q.on[i] = 1'b0;
				next_q.abn[i] = q.abn[i] | trip_abn[i];
				next_q.lim[i] = q.lim[i] | trip_lim[i];
			end else if (next_q.want[i] != q.want[i]) begin
				// A key action owns the branch this cycle, so a stale request cannot reconnect it
				if (next_q.want[i]) begin
					next_q.abn[i] = 1'b0;
					next_q.lim[i] = 1'b0;
				end
			end else if (q.want[i] != q.on[i] && q.booted) begin
				if (q.cnt[i] == 10'h0) begin
					next_q.on[i] = q.want[i]; // RULE5
				end else if (q.tick) begin
					next_q.cnt[i] = q.cnt[i] - 10'h1; // RULE5
				end
			end
			// Indicator encoding
			next_q.green[i] = q.on[i] | (q.want[i] & !q.on[i] & q.flash); // RULE18
			next_q.red[i] = q.abn[i] | (q.lim[i] & q.flash); // RULE18
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			q <= '0;
			q.mode <= M_SET;
			q.level <= LVL_RST; // RULE14
			q.waitrequest <= 1'b1;
		end else begin
			q <= next_q;
		end
	end

	// Registered outputs; mode and level go to the nonvolatile store
	assign avs_readdata = q.readdata;
	assign avs_waitrequest = q.waitrequest;
	assign nv_mode = q.mode; // RULE21
	assign nv_level = q.level; // RULE21
	assign branch_on = q.on;
	assign led_green = q.green;
	assign led_red = q.red;
	assign disp_sel = q.disp;

	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	bus_answer_a: assert property ((avs_read || avs_write) && q.waitrequest |=> !q.waitrequest)
		else $error("no bus answer");
	run_write_a: assert property (wr_take && q.mode == M_RUN |=> $stable(q.start_dly)) // RULE4
		else $error("run mode write taken");
	lvl2_write_a: assert property (wr_take && q.level == 2'h2 |=> $stable(q.stop_dly)) // RULE13
		else $error("level 2 write taken");
	first_boot_a: assert property (!q.booted && !nv_used |=> q.mode == M_SET) // RULE2
		else $error("first boot not setting");
	later_boot_a: assert property (!q.booted && nv_used |=> q.mode == M_RUN && q.want == 4'hf) // RULE3
		else $error("boot not run");
	test_entry_a: assert property ($rose(q.mode == M_TEST) |-> q.on == '0 && $past(q.level) != 2'h2) // RULE9 RULE12
		else $error("bad test entry");
	menu_level_a: assert property ($rose(q.mode == M_MENU) |-> $past(q.level) == 2'h0) // RULE16
		else $error("menu above level 0");
	run_keep_a: assert property ($rose(q.mode == M_RUN) && $past(q.booted) |-> q.want == $past(q.want)) // RULE7
		else $error("run entry changed state");
	// A mode key press may take the branch away, so it is left out here
	seq_zero_a: assert property (q.booted && q.want[0] && !q.on[0] && q.cnt[0] == 10'h0 // RULE5
		&& !k.mode && !trip_abn[0] && !trip_lim[0] |=> q.on[0])
		else $error("branch not connected");
	init_exec_a: assert property (q.mode == M_MENU && q.cursor == ITEM_INIT && k.mode // RULE17
		&& !k.up && !k.down && q.level == 2'h0 && trip_abn == '0 && trip_lim == '0
		|=> q.mode == M_SET && q.level == LVL_RST && q.on == '0)
		else $error("restore incomplete");
	red_led_a: assert property (q.abn[1] |=> (led_red[1] && !led_green[1]) || q.on[1]) // RULE18
		else $error("red indicator wrong");
	// Level 3 is no level; only a menu key action may move the level then
	bad_level_a: assert property (wr_take && idx == IDX_LEVEL && avs_writedata[1:0] == 2'h3 // RULE13
		&& !(q.mode == M_MENU && k.mode) |=> $stable(q.level))
		else $error("level 3 accepted");
	stop_lock_a: assert property (wr_take && q.level != 2'h0 |=> $stable(q.stop_dly)) // RULE13
		else $error("stop delay written above level 0");
	all_on_a: assert property (q.mode == M_TEST && q.cursor == TEST_ALL && k.mode // RULE11
		&& q.want == '0 && !k.up && !k.down && !k.menu && trip_abn == '0 && trip_lim == '0
		|=> q.want == '1 && q.cnt == $past(q.start_dly))
		else $error("all-on not sequenced");
	// Clear loads the live sample, so the peak restarts from now
	peak_clear_a: assert property (q.mode == M_RUN && q.disp == 4'h1 && k.mode && !k.up // RULE20
		&& !k.down && !k.menu |=> q.peak[0] == $past(branch_current[0]))
		else $error("peak not cleared");
	disp_range_a: assert property (q.disp <= DISP_LAST) // RULE19
		else $error("display item out of range");
	// Per-branch checks
	for (genvar g = 0; g < NBR; g++) begin : gen_chk
		trip_cut_a: assert property (trip_abn[g] || trip_lim[g] // RULE18
			|=> !q.on[g] && !q.want[g])
			else $error("trip did not cut branch");
		dark_off_a: assert property (!q.on[g] && !q.want[g] && !q.abn[g] && !q.lim[g] // RULE18
			|=> !led_green[g] && !led_red[g])
			else $error("indicator not dark");
		dly_max_a: assert property (q.start_dly[g] <= DLY_MAX // RULE6
			&& q.stop_dly[g] <= DLY_MAX)
			else $error("delay above range");
		toggle_now_a: assert property (q.mode == M_TEST && q.cursor == 3'(g) && k.mode // RULE10
			&& !k.up && !k.down && !k.menu && !trip_abn[g] && !trip_lim[g]
			|=> q.on[g] != $past(q.on[g]))
			else $error("branch toggle lost");
	end
	test_all_c: cover property (q.mode == M_TEST && q.cursor == TEST_ALL && k.mode);
	peak_clr_c: cover property (q.mode == M_RUN && k.mode && q.disp[0]);
	init_c: cover property (q.mode == M_MENU && q.cursor == ITEM_INIT && k.mode);
	seq_wait_c: cover property (q.want != q.on && q.tick);
	trip_c: cover property (trip_abn != '0 || trip_lim != '0);
endmodule

// file: panel_model.sv
/*
 Front-panel keypad model: a person pressing one key at a time.
 Assumes the bench calls press() and that clk is the block's clock.
*/
`timescale 1ns/1ps
module panel_model (
	// Clock
	input wire logic clk,
	// Raw keys to the block
	output logic [3:0] key_raw
);
	initial begin
		key_raw = 4'h0;
	end
	// Held well past the debounce span, released as long, so one event per press
	task automatic press(input int k);
		@(posedge clk);
		key_raw <= 4'(1 << k);
		repeat (8) @(posedge clk);
		key_raw <= 4'h0;
		repeat (8) @(posedge clk);
		@(negedge clk);
	endtask
endmodule

// file: protector_mode_controller_test.sv
/*
 Self-checking bench of the protector mode controller.
 Assumes short TICK and DEB values; keys come from the panel model.
*/
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin err_total++; \
	$display("unexpected at %0t: got %h want %h", $time, a, b); end end
module protector_mode_controller_test;
	logic clk, rst_b, avs_read, avs_write, avs_waitrequest, nv_used;
	logic [5:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, q;
	logic [3:0] key_raw, trip_abn, trip_lim, nv_mode, branch_on, led_green, led_red, disp_sel, d;
	logic [3:0][7:0] branch_current;
	logic [1:0] nv_level;
	int err_total, compares;
	panel_model panel_model_i (.clk(clk), .key_raw(key_raw));
	prot_ctrl #(.TICK(4), .DEB(3)) prot_ctrl_i (.clk(clk), .rst_b(rst_b),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .key_raw(key_raw),
		.branch_current(branch_current), .trip_abn(trip_abn), .trip_lim(trip_lim),
		.nv_used(nv_used), .nv_mode(nv_mode), .nv_level(nv_level), .branch_on(branch_on),
		.led_green(led_green), .led_red(led_red), .disp_sel(disp_sel));
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	task automatic end_of_test;
		$display("comparisons %0d mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	// Request held until waitrequest is seen low at a rising edge; read data taken there
	task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] dat);
		int n;
		n = 0;
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= dat;
		avs_read <= !wr;
		avs_write <= wr;
		do begin
			@(posedge clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 20);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		if (avs_waitrequest !== 1'b0) begin
			err_total++;
			end_of_test();
		end
		@(negedge clk);
	endtask
	task automatic wait_on(input logic [3:0] v);
		int n;
		for (n = 0; n < 300 && branch_on !== v; n++) @(negedge clk);
		`CHK(branch_on, v)
		if (n >= 300) end_of_test();
	endtask
	task automatic do_reset(input logic used);
		@(posedge clk);
		rst_b <= 1'b0;
		nv_used <= used;
		repeat (16) @(posedge clk);
		rst_b <= 1'b1;
		@(negedge clk);
	endtask
	task automatic t_boot;
		bus(0, 6'h00, 0);
		`CHK(q[3:0], 4'h2)
		`CHK(q[5:4], 2'h1)
		`CHK(nv_mode, 4'h2)
		bus(1, 6'h04, 5);
		bus(0, 6'h04, 0);
		`CHK(q[9:0], 10'h005)
		bus(1, 6'h08, 32'h3ff);
		bus(0, 6'h08, 0);
		`CHK(q[9:0], 10'h3de)
		bus(1, 6'h08, 0);
		bus(1, 6'h14, 7);
		bus(0, 6'h14, 0);
		`CHK(q[9:0], 10'h000)
		bus(0, 6'h38, 0);
		`CHK(q, 32'h0)
		bus(1, 6'h34, 32'hffff_ffff);
		bus(0, 6'h35, 0);
		`CHK(q[1:0], 2'h1)
		`CHK(nv_level, 2'h1)
		panel_model_i.press(3);
		bus(0, 6'h00, 0);
		`CHK(q[3:0], 4'h2)
		$display("test boot done");
	endtask
	task automatic t_test;
		bus(1, 6'h34, 0);
		panel_model_i.press(3);
		bus(0, 6'h00, 0);
		`CHK(q[3:0], 4'h8)
		panel_model_i.press(0);
		panel_model_i.press(0);
		bus(0, 6'h00, 0);
		`CHK(q[28:26], 3'h2)
		panel_model_i.press(2);
		bus(0, 6'h00, 0);
		`CHK(q[3:0], 4'h4)
		`CHK(branch_on, 4'h0)
		panel_model_i.press(2);
		`CHK(branch_on, 4'h1)
		panel_model_i.press(2);
		`CHK(branch_on, 4'h0)
		repeat (4) panel_model_i.press(0);
		panel_model_i.press(2);
		`CHK(branch_on, 4'he)
		wait_on(4'hf);
		@(negedge clk);
		`CHK(led_green, 4'hf)
		$display("test forcing done");
	endtask
	task automatic t_run;
		panel_model_i.press(3);
		panel_model_i.press(2);
		bus(0, 6'h00, 0);
		`CHK(q[3:0], 4'h1)
		`CHK(branch_on, 4'hf)
		bus(1, 6'h04, 9);
		bus(0, 6'h04, 0);
		`CHK(q[9:0], 10'h005)
		@(posedge clk);
		branch_current[0] <= 8'h50;
		@(posedge clk);
		branch_current[0] <= 8'h18;
		bus(0, 6'h27, 0);
		`CHK(q[7:0], 8'h50)
		d = disp_sel;
		panel_model_i.press(0);
		`CHK(disp_sel, d + 4'h1)
		panel_model_i.press(2);
		bus(0, 6'h24, 0);
		`CHK(q[7:0], 8'h18)
		panel_model_i.press(1);
		`CHK(disp_sel, d)
		@(posedge clk);
		trip_abn <= 4'h2;
		trip_lim <= 4'h4;
		repeat (4) @(posedge clk);
		trip_abn <= 4'h0;
		trip_lim <= 4'h0;
		@(negedge clk);
		`CHK(branch_on, 4'h9)
		`CHK(led_red[1], 1'b1)
		`CHK(led_green[2:1], 2'h0)
		$display("test run done");
	endtask
	task automatic t_restore;
		panel_model_i.press(3);
		panel_model_i.press(0);
		panel_model_i.press(0);
		bus(1, 6'h34, 2);
		panel_model_i.press(2);
		bus(0, 6'h00, 0);
		`CHK(q[3:0], 4'h8)
		bus(1, 6'h34, 0);
		panel_model_i.press(1);
		panel_model_i.press(2);
		bus(1, 6'h14, 32'hffff_fc07);
		bus(0, 6'h14, 0);
		`CHK(q[9:0], 10'h007)
		`CHK(branch_on, 4'h9)
		panel_model_i.press(3);
		panel_model_i.press(1);
		panel_model_i.press(2);
		bus(0, 6'h00, 0);
		`CHK(q[5:0], 6'h12)
		`CHK(branch_on, 4'h0)
		bus(0, 6'h04, 0);
		`CHK(q[9:0], 10'h000)
		bus(0, 6'h14, 0);
		`CHK(q[9:0], 10'h000)
		$display("test restore done");
	endtask
	initial begin
		rst_b = 1'b0;
		nv_used = 1'b0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_address = 6'h00;
		avs_writedata = 32'h0;
		trip_abn = 4'h0;
		trip_lim = 4'h0;
		branch_current = {8'h40, 8'h30, 8'h20, 8'h10};
		err_total = 0;
		compares = 0;
		do_reset(1'b0);
		t_boot();
		t_test();
		t_run();
		t_restore();
		// Second power-up with the store written
		do_reset(1'b1);
		bus(0, 6'h00, 0);
		`CHK(q[3:0], 4'h1)
		wait_on(4'hf);
		$display("test power-up done");
		end_of_test();
	end
endmodule
